// ### hdl/idm_defines.svh
// Address map, reset values and widths of the internal data memory
`ifndef IDM_DEFINES_SVH
`define IDM_DEFINES_SVH
`define IDM_ADDR_W      8
`define IDM_DATA_W      8
`define IDM_DEPTH       256
`define IDM_PC_W        16
`define IDM_STK_RESET   8'h07
`define IDM_BIT_BASE    8'h20
`define IDM_UPPER_BIT   7
`define IDM_BANK_LSB    3
`define IDM_BITPOS_W    3
`define IDM_ONE         8'h01
`define IDM_ZERO        8'h00
`endif

// ### hdl/idm_pkg.sv
// Operation codes and controller states of the internal data memory
package idm_pkg;
    typedef enum logic [3:0] {
        op_dir_rd  = 4'h0,
        op_dir_wr  = 4'h1,
        op_ind_rd  = 4'h2,
        op_ind_wr  = 4'h3,
        op_reg_rd  = 4'h4,
        op_reg_wr  = 4'h5,
        op_bit_rd  = 4'h6,
        op_bit_wr  = 4'h7,
        op_push    = 4'h8,
        op_pop     = 4'h9,
        op_call    = 4'hA,
        op_return  = 4'hB,
        op_stk_wr  = 4'hC
    } idm_op_t;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_wait   = 2'b01,
        st_second = 2'b11
    } idm_state_t;
endpackage

// ### hdl/idm_mem_if.sv
// Port between the memory controller and the byte array
`timescale 1ns/1ns
`include "idm_defines.svh"
interface idm_mem_if;
    logic                     we;
    logic [`IDM_ADDR_W-1:0]   addr;
    logic [`IDM_DATA_W-1:0]   wdata;
    logic [`IDM_DATA_W-1:0]   rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ### hdl/idm_ram.sv
// Single-port byte array with registered read data
`timescale 1ns/1ns
`include "idm_defines.svh"
module idm_ram #(
    parameter int WIDTH = `IDM_DATA_W,
    parameter int DEPTH = `IDM_DEPTH
) (
    input  wire logic mclk,
    input  wire logic rstn,
    idm_mem_if.mem    port
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdata_r;
    logic [WIDTH-1:0] rdata_nxt;

    if (WIDTH != `IDM_DATA_W || DEPTH != (1 << `IDM_ADDR_W)) begin : g_chk
        $error("idm_ram: size must match the byte address space");
    end

    // Read-before-write: a write returns the old byte
    always_comb begin
        rdata_nxt = mem_q[port.addr];
    end

    // Array is not reset; contents are undefined after power-up
    always_ff @(posedge mclk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign port.rdata = rdata_r;
endmodule

// ### hdl/idm_core.sv
// Internal data memory controller with banks, bit area and stack pointer
//
// How it works
// - 256 bytes, eight-bit address
// - lower half: direct and indirect reach RAM
// - upper half: indirect RAM, direct special space
// - lowest 32 bytes: four banks, status-word select
// - bytes 20h-2Fh hold 128 single bits
// - bit address: byte 20h+upper bits, position low
// - stack pointer resets to 07h
// - push: pointer plus one, then write
// - call or interrupt entry: two bytes, plus two
// - pop minus one; return minus two
// - software may load pointer anywhere
// - no bounds check, no flag
`timescale 1ns/1ns
`include "idm_defines.svh"
module idm_core #(
    parameter int ADDR_W = `IDM_ADDR_W,
    parameter int DATA_W = `IDM_DATA_W
) (
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    input  wire logic                    req_valid,
    input  wire idm_pkg::idm_op_t        req_op,
    input  wire logic [ADDR_W-1:0]       req_addr,
    input  wire logic [DATA_W-1:0]       req_wdata,
    input  wire logic                    req_bit,
    input  wire logic [`IDM_PC_W-1:0]    req_pc,
    input  wire logic                    bank_select_low,
    input  wire logic                    bank_select_high,
    input  wire logic [DATA_W-1:0]       sfs_rdata,
    output logic                         req_ready_r,
    output logic                         rsp_valid_r,
    output logic [DATA_W-1:0]            rsp_data_r,
    output logic                         rsp_bit_r,
    output logic [`IDM_PC_W-1:0]         rsp_pc_r,
    output logic [ADDR_W-1:0]            stack_pointer_r,
    output logic                         sfs_strobe_r,
    output logic                         sfs_we_r,
    output logic [ADDR_W-1:0]            sfs_addr_r,
    output logic [DATA_W-1:0]            sfs_wdata_r
);
    import idm_pkg::*;

    if (ADDR_W != `IDM_ADDR_W || DATA_W != `IDM_DATA_W) begin : g_chk
        $error("idm_core: only an 8-bit address and 8-bit data are served");
    end

    idm_mem_if mem ();

    idm_ram #(
        .WIDTH (DATA_W),
        .DEPTH (1 << ADDR_W)
    ) u_ram (
        .mclk (mclk),
        .rstn (rstn),
        .port (mem)
    );

    function automatic logic [ADDR_W-1:0] bit_byte(input logic [ADDR_W-1:0] a);
        bit_byte = `IDM_BIT_BASE + {`IDM_BITPOS_W'(0), a[ADDR_W-2:`IDM_BITPOS_W]};
    endfunction

    function automatic logic [DATA_W-1:0] put_bit(input logic [DATA_W-1:0] b,
                                                   input logic [`IDM_BITPOS_W-1:0] p,
                                                   input logic v);
        logic [DATA_W-1:0] r;
        r    = b;
        r[p] = v;
        put_bit = r;
    endfunction

    idm_state_t               state_r;
    idm_state_t               state_nxt;
    idm_op_t                  op_r;
    idm_op_t                  op_nxt;
    logic [ADDR_W-1:0]        addr_r;
    logic [ADDR_W-1:0]        addr_nxt;
    logic [`IDM_BITPOS_W-1:0] bitpos_r;
    logic [`IDM_BITPOS_W-1:0] bitpos_nxt;
    logic                     bitval_r;
    logic                     bitval_nxt;
    logic [DATA_W-1:0]        hi_r;
    logic [DATA_W-1:0]        hi_nxt;
    logic                     sfs_sel_r;
    logic                     sfs_sel_nxt;
    logic                     req_ready_nxt;
    logic                     rsp_valid_nxt;
    logic [DATA_W-1:0]        rsp_data_nxt;
    logic                     rsp_bit_nxt;
    logic [`IDM_PC_W-1:0]     rsp_pc_nxt;
    logic [ADDR_W-1:0]        stack_pointer_nxt;
    logic                     sfs_strobe_nxt;
    logic                     sfs_we_nxt;
    logic [ADDR_W-1:0]        sfs_addr_nxt;
    logic [DATA_W-1:0]        sfs_wdata_nxt;
    logic                     mem_we;
    logic [ADDR_W-1:0]        mem_addr;
    logic [DATA_W-1:0]        mem_wdata;
    logic [DATA_W-1:0]        rd_byte;
    logic [ADDR_W-1:0]        stk_inc;
    logic [ADDR_W-1:0]        stk_dec;
    logic [ADDR_W-1:0]        tgt;
    logic                     upper;

    assign mem.we    = mem_we;
    assign mem.addr  = mem_addr;
    assign mem.wdata = mem_wdata;

    always_comb begin
        state_nxt      = state_r;
        op_nxt         = op_r;
        addr_nxt       = addr_r;
        bitpos_nxt     = bitpos_r;
        bitval_nxt     = bitval_r;
        hi_nxt         = hi_r;
        sfs_sel_nxt    = sfs_sel_r;
        stack_pointer_nxt = stack_pointer_r;
        rsp_valid_nxt  = 1'b0;
        rsp_data_nxt   = rsp_data_r;
        rsp_bit_nxt    = rsp_bit_r;
        rsp_pc_nxt     = rsp_pc_r;
        sfs_strobe_nxt = 1'b0;
        sfs_we_nxt     = 1'b0;
        sfs_addr_nxt   = sfs_addr_r;
        sfs_wdata_nxt  = sfs_wdata_r;
        mem_we         = 1'b0;
        mem_addr       = addr_r;
        mem_wdata      = req_wdata;
        rd_byte        = sfs_sel_r ? sfs_rdata : mem.rdata;
        stk_inc        = stack_pointer_r + `IDM_ONE;
        stk_dec        = stack_pointer_r - `IDM_ONE;
        upper          = req_addr[`IDM_UPPER_BIT];
        tgt            = req_addr;
        unique case (req_op)
            op_reg_rd, op_reg_wr: tgt = {`IDM_BITPOS_W'(0), bank_select_high, bank_select_low,
                                         req_addr[`IDM_BANK_LSB-1:0]};
            op_bit_rd, op_bit_wr: tgt = bit_byte(req_addr);
            op_push, op_call:     tgt = stk_inc;
            op_pop, op_return:    tgt = stack_pointer_r;
            default:              tgt = req_addr;
        endcase

        unique case (state_r)
            st_idle: begin
                if (req_valid) begin
                    op_nxt      = req_op;
                    addr_nxt    = tgt;
                    mem_addr    = tgt;
                    bitpos_nxt  = req_addr[`IDM_BITPOS_W-1:0];
                    bitval_nxt  = req_bit;
                    hi_nxt      = req_pc[`IDM_PC_W-1:DATA_W];
                    sfs_sel_nxt = 1'b0;
                    unique case (req_op)
                        op_dir_rd, op_dir_wr: begin
                            // upper half direct leaves for special space
                            if (upper) begin
                                sfs_sel_nxt    = 1'b1;
                                sfs_strobe_nxt = 1'b1;
                                sfs_we_nxt     = (req_op == op_dir_wr);
                                sfs_addr_nxt   = req_addr;
                                sfs_wdata_nxt  = req_wdata;
                            end else if (req_op == op_dir_wr) begin
                                mem_we = 1'b1;
                            end
                            if (req_op == op_dir_rd) begin
                                state_nxt = st_wait;
                            end else begin
                                rsp_valid_nxt = 1'b1;
                            end
                        end
                        op_ind_wr, op_reg_wr: begin
                            mem_we        = 1'b1;
                            rsp_valid_nxt = 1'b1;
                        end
                        op_push: begin
                            mem_we            = 1'b1;
                            stack_pointer_nxt = stk_inc;
                            rsp_valid_nxt     = 1'b1;
                        end
                        op_call: begin
                            mem_we            = 1'b1;
                            mem_wdata         = req_pc[DATA_W-1:0];
                            stack_pointer_nxt = stk_inc;
                            state_nxt         = st_second;
                        end
                        op_pop, op_return: begin
                            stack_pointer_nxt = stk_dec;
                            state_nxt         = st_wait;
                        end
                        op_stk_wr: begin
                            stack_pointer_nxt = req_wdata;
                            rsp_valid_nxt = 1'b1;
                        end
                        default: begin
                            state_nxt = st_wait;
                        end
                    endcase
                end
            end
            st_wait: begin
                state_nxt     = st_idle;
                rsp_valid_nxt = 1'b1;
                rsp_data_nxt  = rd_byte;
                unique case (op_r)
                    op_bit_rd: begin
                        rsp_bit_nxt = rd_byte[bitpos_r];
                    end
                    op_bit_wr: begin
                        mem_we      = 1'b1;
                        mem_wdata   = put_bit(rd_byte, bitpos_r, bitval_r);
                        rsp_bit_nxt = bitval_r;
                    end
                    op_return: begin
                        hi_nxt        = rd_byte;
                        mem_addr      = stack_pointer_r;
                        stack_pointer_nxt = stk_dec;
                        rsp_valid_nxt = 1'b0;
                        state_nxt     = st_second;
                    end
                    default: begin
                        rsp_bit_nxt = rsp_bit_r;
                    end
                endcase
            end
            st_second: begin
                state_nxt     = st_idle;
                rsp_valid_nxt = 1'b1;
                if (op_r == op_call) begin
                    mem_we    = 1'b1;
                    mem_addr  = stk_inc;
                    mem_wdata = hi_r;
                    stack_pointer_nxt = stk_inc;
                end else begin
                    rsp_pc_nxt = {hi_r, mem.rdata};
                end
            end
            default: begin
                state_nxt = st_idle;
            end
        endcase
        req_ready_nxt = (state_nxt == st_idle);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r         <= st_idle;
            op_r            <= op_dir_rd;
            addr_r          <= `IDM_ZERO;
            bitpos_r        <= '0;
            bitval_r        <= 1'b0;
            hi_r            <= `IDM_ZERO;
            sfs_sel_r       <= 1'b0;
            req_ready_r     <= 1'b1;
            rsp_valid_r     <= 1'b0;
            rsp_data_r      <= `IDM_ZERO;
            rsp_bit_r       <= 1'b0;
            rsp_pc_r        <= '0;
            stack_pointer_r <= `IDM_STK_RESET;
            sfs_strobe_r    <= 1'b0;
            sfs_we_r        <= 1'b0;
            sfs_addr_r      <= `IDM_ZERO;
            sfs_wdata_r     <= `IDM_ZERO;
        end else begin
            state_r         <= state_nxt;
            op_r            <= op_nxt;
            addr_r          <= addr_nxt;
            bitpos_r        <= bitpos_nxt;
            bitval_r        <= bitval_nxt;
            hi_r            <= hi_nxt;
            sfs_sel_r       <= sfs_sel_nxt;
            req_ready_r     <= req_ready_nxt;
            rsp_valid_r     <= rsp_valid_nxt;
            rsp_data_r      <= rsp_data_nxt;
            rsp_bit_r       <= rsp_bit_nxt;
            rsp_pc_r        <= rsp_pc_nxt;
            stack_pointer_r <= stack_pointer_nxt;
            sfs_strobe_r    <= sfs_strobe_nxt;
            sfs_we_r        <= sfs_we_nxt;
            sfs_addr_r      <= sfs_addr_nxt;
            sfs_wdata_r     <= sfs_wdata_nxt;
        end
    end
endmodule

// ### testbench/idm_core_sva.sv
// Port-level assertions for the internal data memory controller
`timescale 1ns/1ns
module idm_core_sva (
    input wire logic              mclk,
    input wire logic              rstn,
    input wire logic              req_valid,
    input wire idm_pkg::idm_op_t  req_op,
    input wire logic [7:0]        req_addr,
    input wire logic [7:0]        req_wdata,
    input wire logic              req_ready_r,
    input wire logic              rsp_valid_r,
    input wire logic [7:0]        stack_pointer_r,
    input wire logic              sfs_strobe_r,
    input wire logic              sfs_we_r,
    input wire logic [7:0]        sfs_addr_r
);
    import idm_pkg::*;
    logic tk;
    logic dir_op;
    assign tk     = req_valid && req_ready_r;
    assign dir_op = (req_op == op_dir_rd) || (req_op == op_dir_wr);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_reset_sp: assert property (
        $rose(rstn) |-> stack_pointer_r == 8'h07) else $error("stack pointer not 07 after reset");
    a_push_adv: assert property (
        tk && req_op == op_push |=> rsp_valid_r && stack_pointer_r == $past(stack_pointer_r) + 8'h01)
        else $error("push did not advance pointer by one");
    a_pop_down: assert property (
        tk && req_op == op_pop |=> !req_ready_r && stack_pointer_r == $past(stack_pointer_r) - 8'h01
        ##1 rsp_valid_r && req_ready_r) else $error("pop did not lower pointer by one");
    a_call_two: assert property (
        tk && req_op == op_call |=> !rsp_valid_r ##1 rsp_valid_r
        && stack_pointer_r == $past(stack_pointer_r, 2) + 8'h02) else $error("call did not add two");
    a_return_two: assert property (
        tk && req_op == op_return |=> ##1 stack_pointer_r == $past(stack_pointer_r, 2) - 8'h02
        ##1 rsp_valid_r) else $error("return did not subtract two");
    a_stk_load: assert property (
        tk && req_op == op_stk_wr |=> stack_pointer_r == $past(req_wdata)) else $error("pointer load lost");
    a_dir_upper: assert property (
        tk && dir_op && req_addr[7] |=> sfs_strobe_r && sfs_addr_r == $past(req_addr)
        && sfs_we_r == ($past(req_op) == op_dir_wr)) else $error("direct upper access missed special space");
    a_no_special: assert property (
        tk && !(dir_op && req_addr[7]) && req_op != op_stk_wr |=> !sfs_strobe_r)
        else $error("special space strobed by a RAM access");
endmodule
bind idm_core idm_core_sva u_sva (.mclk, .rstn, .req_valid, .req_op, .req_addr, .req_wdata, .req_ready_r,
    .rsp_valid_r, .stack_pointer_r, .sfs_strobe_r, .sfs_we_r, .sfs_addr_r);

// ### testbench/idm_sfr_model.sv
// Special-function space stand-in behind the direct upper-half port
`timescale 1ns/1ns
module idm_sfs_model (
    input  wire logic       mclk,
    input  wire logic       sfs_strobe_r,
    input  wire logic       sfs_we_r,
    input  wire logic [7:0] sfs_addr_r,
    input  wire logic [7:0] sfs_wdata_r,
    output logic      [7:0] sfs_rdata
);
    logic [7:0] regs [128];
    logic [7:0] junk = 8'h00;
    always @(posedge mclk) begin
        junk <= ~junk;
        if (sfs_strobe_r && sfs_we_r) begin
            regs[sfs_addr_r[6:0]] <= sfs_wdata_r;
        end
    end
    // Toggling pattern outside a read strobe, so stale data never passes
    assign sfs_rdata = (sfs_strobe_r && !sfs_we_r) ? regs[sfs_addr_r[6:0]] : junk;
endmodule

// ### testbench/tb_internal_ram_stack_addressing.sv
// Self-checking bench for the internal data memory controller
`timescale 1ns/1ns
module tb_internal_ram_stack_addressing;
    import idm_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        req_valid = 1'b0;
    idm_op_t     req_op = op_dir_rd;
    logic [7:0]  req_addr = 8'h00;
    logic [7:0]  req_wdata = 8'h00;
    logic        req_bit = 1'b0;
    logic [15:0] req_pc = 16'h0000;
    logic        bank_select_low = 1'b0;
    logic        bank_select_high = 1'b0;
    logic [7:0]  sfs_rdata;
    logic        req_ready_r;
    logic        rsp_valid_r;
    logic [7:0]  rsp_data_r;
    logic        rsp_bit_r;
    logic [15:0] rsp_pc_r;
    logic [7:0]  stack_pointer_r;
    logic        sfs_strobe_r;
    logic        sfs_we_r;
    logic [7:0]  sfs_addr_r;
    logic [7:0]  sfs_wdata_r;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    idm_core uut (.mclk, .rstn, .req_valid, .req_op, .req_addr, .req_wdata, .req_bit, .req_pc,
        .bank_select_low, .bank_select_high, .sfs_rdata, .req_ready_r, .rsp_valid_r, .rsp_data_r,
        .rsp_bit_r, .rsp_pc_r, .stack_pointer_r, .sfs_strobe_r, .sfs_we_r, .sfs_addr_r, .sfs_wdata_r);
    idm_sfs_model u_sfs (.mclk, .sfs_strobe_r, .sfs_we_r, .sfs_addr_r, .sfs_wdata_r, .sfs_rdata);
    always #5 mclk = ~mclk;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One request, held for one clock without waiting for ready, then waits up to 8 clocks for its answer; call takes its address as {a, d}
    task automatic req(input idm_op_t op, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        req_bit <= d[0];
        req_pc <= {a, d};
        @(posedge mclk);
        req_valid <= 1'b0;
        #1;
        for (i = 0; i < 8 && rsp_valid_r !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        check(16'(i < 8), 16'h0001);
    endtask
    task automatic t_halves;
        req(op_dir_wr, 8'h35, 8'hA5);
        req(op_ind_rd, 8'h35, 8'h00);
        check(rsp_data_r, 8'hA5);
        req(op_ind_wr, 8'h7F, 8'h3C);
        req(op_dir_rd, 8'h7F, 8'h00);
        check(rsp_data_r, 8'h3C);
        req(op_ind_wr, 8'h90, 8'h11);
        req(op_dir_wr, 8'h90, 8'h22);
        req(op_ind_rd, 8'h90, 8'h00);
        check(rsp_data_r, 8'h11);
        req(op_dir_rd, 8'h90, 8'h00);
        check(rsp_data_r, 8'h22);
        $display("t_halves done");
    endtask
    task automatic t_banks;
        logic [7:0] b;
        for (b = 0; b < 4; b++) begin
            @(posedge mclk);
            {bank_select_high, bank_select_low} <= b[1:0];
            req(op_reg_wr, 8'h05, 8'h40 + b);
        end
        for (b = 0; b < 4; b++) begin
            req(op_dir_rd, b * 8'h08 + 8'h05, 8'h00);
            check(rsp_data_r, 8'h40 + b);
        end
        @(posedge mclk);
        {bank_select_high, bank_select_low} <= 2'b10;
        req(op_reg_rd, 8'h05, 8'h00);
        check(rsp_data_r, 8'h42);
        $display("t_banks done");
    endtask
    task automatic t_bits;
        req(op_dir_wr, 8'h28, 8'h00);
        req(op_bit_wr, 8'h42, 8'h01);
        req(op_dir_rd, 8'h28, 8'h00);
        check(rsp_data_r, 8'h04);
        req(op_dir_wr, 8'h2F, 8'h5A);
        req(op_bit_wr, 8'h78, 8'h01);
        req(op_bit_wr, 8'h7F, 8'h01);
        req(op_bit_wr, 8'h79, 8'h00);
        req(op_dir_rd, 8'h2F, 8'h00);
        check(rsp_data_r, 8'hD9);
        req(op_bit_rd, 8'h79, 8'h00);
        check(rsp_bit_r, 1'b0);
        req(op_bit_rd, 8'h7F, 8'h00);
        check(rsp_bit_r, 1'b1);
        $display("t_bits done");
    endtask
    task automatic t_stack;
        check(stack_pointer_r, 8'h07);
        req(op_push, 8'h00, 8'h12);
        check(stack_pointer_r, 8'h08);
        req(op_dir_rd, 8'h08, 8'h00);
        check(rsp_data_r, 8'h12);
        req(op_call, 8'hBE, 8'hEF);
        check(stack_pointer_r, 8'h0A);
        req(op_dir_rd, 8'h09, 8'h00);
        check(rsp_data_r, 8'hEF);
        req(op_dir_rd, 8'h0A, 8'h00);
        check(rsp_data_r, 8'hBE);
        req(op_return, 8'h00, 8'h00);
        check(rsp_pc_r, 16'hBEEF);
        check(stack_pointer_r, 8'h08);
        req(op_pop, 8'h00, 8'h00);
        check(rsp_data_r, 8'h12);
        check(stack_pointer_r, 8'h07);
        $display("t_stack done");
    endtask
    task automatic t_place;
        req(op_stk_wr, 8'h00, 8'hBF);
        req(op_push, 8'h00, 8'h77);
        check(stack_pointer_r, 8'hC0);
        req(op_ind_rd, 8'hC0, 8'h00);
        check(rsp_data_r, 8'h77);
        req(op_stk_wr, 8'h00, 8'hFF);
        req(op_push, 8'h00, 8'h99);
        check(stack_pointer_r, 8'h00);
        req(op_ind_rd, 8'h00, 8'h00);
        check(rsp_data_r, 8'h99);
        req(op_pop, 8'h00, 8'h00);
        check(stack_pointer_r, 8'hFF);
        $display("t_place done");
    endtask
    // Mid-run reset must bring the pointer back whatever software left in it
    task automatic t_reset;
        req(op_stk_wr, 8'h00, 8'h55);
        check(stack_pointer_r, 8'h55);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        check(stack_pointer_r, 8'h07);
        check(req_ready_r, 1'b1);
        req(op_push, 8'h00, 8'h3C);
        req(op_ind_rd, 8'h08, 8'h00);
        check(rsp_data_r, 8'h3C);
        $display("t_reset done");
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        t_halves();
        t_banks();
        t_bits();
        t_stack();
        t_place();
        t_reset();
        give_verdict();
    end
endmodule
